// *** src/sbp_regs.sv ***
// base configuration and status register bank of the serial bus phy
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - contender flag drives self-id bit 20
// - contender clears on hardware reset, survives bus reset, set only by write
// - repeater skew field is read-only zero
// - power class loaded from straps at reset, kept on bus reset, in self-id 21-23
// - resume on any port sets port event when resume watch enabled
// - short reset request starts 1.3 us bus reset, cleared by any bus reset
// - short reset becomes long reset when a legacy node cannot do short
// - config timeout flag set by tree-id timeout, write one clears
// - any timeout or power flag with watch enable raises link-on while link inactive
// - cable power drop set on sense falling, one after reset, write one clears
// - state timeout sets its flag and forces a long bus reset when the sequencer is idle
// - port status change on enabled port sets port event flag
// - fast arbitration enable, zero at reset, ignored in beta mode
// - mixed speed concat enable, zero at reset, ignored in beta mode
// - legacy path top speed from received self-ids, capped at s400
// - beta capable link flag follows beta mode strap
// - bridge field feeds self-id, zero after reset
// - page choice selects page for the port status register at 0x14, zero at reset
// - port choice selects port, zero at reset
// - unimplemented selected port reads all zero
module sbp_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] power_class_straps,
  input wire logic beta_mode_strap,
  input wire logic beta_mode_active,
  input wire logic cable_power_sense,
  input wire logic link_active,
  input wire sbp_pkg::sbp_port_type port_stat,
  input wire logic [2:0] port_event_enable,
  input wire sbp_pkg::sbp_arb_type arb,
  output logic [23:18] selfid_bits,
  output logic bus_reset_start,
  output logic bus_reset_long,
  output logic bus_reset_active,
  output logic link_on_output,
  output logic fast_arb_active,
  output logic mixed_concat_active
);
  import sbp_pkg::*;

  logic contender_q;
  logic [2:0] pwr_class_q;
  logic resume_watch_irq_enable_q;
  logic short_reset_request_q;
  logic config_timeout_flag_q;
  logic cable_power_drop_flag_q;
  logic state_timeout_flag_q;
  logic port_event_flag_q;
  logic fast_arbitration_enable_q;
  logic mixed_speed_concat_enable_q;
  logic [2:0] legacy_path_top_speed_q;
  logic [1:0] bridge_q;
  logic [2:0] page_q;
  logic [3:0] port_q;
  logic cps_prev_q;
  logic strap_load_q;
  logic [7:0] rst_cnt_q;
  sbp_port_type port_prev_q;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHORT = 2'b01,
    ST_LONG = 2'b10
  } sbp_rst_type;
  sbp_rst_type rst_state_q;

  // apb access strobes; zero wait states, so access completes on first penable
  logic wr_en;
  logic rd_en;
  logic bus_reset_evt;
  logic [2:0] port_change;
  logic port_event_set;
  logic clr_hit;
  logic [31:0] rd_d;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic w1c(input logic flag, input logic set, input logic clr);
    // set beats a simultaneous clear so no event is lost
    return set | (flag & ~clr);
  endfunction

  // any bus reset finishing or starting clears the short request
  assign bus_reset_evt = bus_reset_start || arb.bus_reset_done;

  // contender, watch enable and strap capture; bus reset leaves them alone
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      contender_q <= 1'b0;
      resume_watch_irq_enable_q <= 1'b0;
      strap_load_q <= 1'b1;
    end else begin
      strap_load_q <= 1'b0;
      if (wr_en && hit(paddr, OFS_CONFIG)) begin
        contender_q <= pwdata[CFG_CONTENDER_POS];
        resume_watch_irq_enable_q <= pwdata[CFG_WATCH_POS];
      end
    end
  end

  // straps caught on the first clock after reset release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwr_class_q <= 3'h0;
    end else if (strap_load_q) begin
      pwr_class_q <= power_class_straps;
    end else if (wr_en && hit(paddr, OFS_CONFIG)) begin
      pwr_class_q <= pwdata[CFG_PWR_POS +: 3];
    end
  end

  // short reset request: a write of one wins over a clear from an older reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      short_reset_request_q <= 1'b0;
    end else if (wr_en && hit(paddr, OFS_CONFIG) && pwdata[CFG_SHORT_RST_POS]) begin
      short_reset_request_q <= 1'b1;
    end else if (bus_reset_evt) begin
      short_reset_request_q <= 1'b0;
    end
  end

  // bus reset sequencer; the request is honoured once the sequencer is idle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_state_q <= ST_IDLE;
      rst_cnt_q <= 8'h00;
      bus_reset_start <= 1'b0;
      bus_reset_long <= 1'b0;
      bus_reset_active <= 1'b0;
    end else begin
      bus_reset_start <= 1'b0;
      bus_reset_active <= (rst_state_q != ST_IDLE) || bus_reset_start;
      unique case (rst_state_q)
        ST_IDLE: begin
          if (arb.state_timeout) begin
            rst_state_q <= ST_LONG;
            bus_reset_start <= 1'b1;
            bus_reset_long <= 1'b1;
          end else if (short_reset_request_q) begin
            bus_reset_start <= 1'b1;
            bus_reset_long <= arb.legacy_no_short;
            rst_state_q <= arb.legacy_no_short ? ST_LONG : ST_SHORT;
            rst_cnt_q <= SHORT_RESET_CNT;
          end
        end
        ST_SHORT: begin
          // short reset timed here; long one is ended by the arbitration core
          if (rst_cnt_q == 8'h01) begin
            rst_state_q <= ST_IDLE;
          end
          rst_cnt_q <= rst_cnt_q - 8'h01;
        end
        ST_LONG: begin
          if (arb.bus_reset_done) begin
            rst_state_q <= ST_IDLE;
            bus_reset_long <= 1'b0;
          end
        end
        default: rst_state_q <= ST_IDLE;
      endcase
    end
  end

  // interrupt flags, write one to clear, writing zero does nothing
  assign clr_hit = wr_en && hit(paddr, OFS_IRQ);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      config_timeout_flag_q <= 1'b0;
      cable_power_drop_flag_q <= 1'b1;
      state_timeout_flag_q <= 1'b0;
      port_event_flag_q <= 1'b0;
    end else begin
      config_timeout_flag_q <= w1c(config_timeout_flag_q, arb.cfg_timeout,
                                   clr_hit && pwdata[IRQ_CFG_TO_POS]);
      cable_power_drop_flag_q <= w1c(cable_power_drop_flag_q, cps_prev_q && !cable_power_sense,
                                     clr_hit && pwdata[IRQ_CPWR_POS]);
      state_timeout_flag_q <= w1c(state_timeout_flag_q, arb.state_timeout,
                                  clr_hit && pwdata[IRQ_STATE_TO_POS]);
      port_event_flag_q <= w1c(port_event_flag_q, port_event_set,
                               clr_hit && pwdata[IRQ_PORT_EV_POS]);
    end
  end

  // previous levels for edge and change detection
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cps_prev_q <= 1'b1; // idle level of the sense pin, no false fall
      port_prev_q <= '0;
    end else begin
      cps_prev_q <= cable_power_sense;
      port_prev_q <= port_stat;
    end
  end

  // port status change gated per port; resume start gated by watch enable
  assign port_change = (port_stat.connected ^ port_prev_q.connected) |
                       (port_stat.bias ^ port_prev_q.bias) |
                       (port_stat.disabled ^ port_prev_q.disabled) |
                       (port_stat.fault ^ port_prev_q.fault);
  assign port_event_set = |(port_change & port_event_enable) ||
                          (resume_watch_irq_enable_q && |port_stat.resume_start);

  // registered outputs; link-on only while the link is down, beta mode masks acceleration
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link_on_output <= 1'b0;
      fast_arb_active <= 1'b0;
      mixed_concat_active <= 1'b0;
      selfid_bits <= 6'h00;
    end else begin
      link_on_output <= resume_watch_irq_enable_q && !link_active &&
                        (config_timeout_flag_q || cable_power_drop_flag_q || state_timeout_flag_q);
      fast_arb_active <= fast_arbitration_enable_q && !beta_mode_active;
      mixed_concat_active <= mixed_speed_concat_enable_q && !beta_mode_active;
      selfid_bits[SID_CONTENDER_BIT] <= contender_q;
      selfid_bits[SID_PWR_POS +: 3] <= pwr_class_q;
      selfid_bits[SID_BRIDGE_POS +: 2] <= bridge_q;
    end
  end

  // arbitration options and bridge field
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fast_arbitration_enable_q <= 1'b0;
      mixed_speed_concat_enable_q <= 1'b0;
      bridge_q <= BRIDGE_RESET;
    end else if (wr_en && hit(paddr, OFS_MODE)) begin
      fast_arbitration_enable_q <= pwdata[MODE_FAST_POS];
      mixed_speed_concat_enable_q <= pwdata[MODE_MIXED_POS];
      bridge_q <= pwdata[MODE_BRIDGE_POS +: 2];
    end
  end

  // legacy speed: restart on each bus reset, keep highest seen, cap at s400
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      legacy_path_top_speed_q <= 3'h0;
    end else if (bus_reset_start) begin
      legacy_path_top_speed_q <= 3'h0;
    end else if (arb.legacy_speed_valid) begin
      if (arb.legacy_speed > legacy_path_top_speed_q) begin
        legacy_path_top_speed_q <= (arb.legacy_speed > SPEED_S400) ? SPEED_S400 : arb.legacy_speed;
      end
    end
  end

  // page and port choice
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      page_q <= PAGE_RESET;
      port_q <= PORT_RESET;
    end else if (wr_en && hit(paddr, OFS_SELECT)) begin
      page_q <= pwdata[SEL_PAGE_POS +: 3];
      port_q <= pwdata[SEL_PORT_POS +: 4];
    end
  end

  // read mux; port page is only meaningful on page zero for a real port
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      OFS_CONFIG: begin
        rd_d[CFG_CONTENDER_POS] = contender_q;
        rd_d[CFG_SKEW_POS +: 3] = SKEW_VALUE;
        rd_d[CFG_PWR_POS +: 3] = pwr_class_q;
        rd_d[CFG_WATCH_POS] = resume_watch_irq_enable_q;
        rd_d[CFG_SHORT_RST_POS] = short_reset_request_q;
      end
      OFS_IRQ: begin
        rd_d[IRQ_CFG_TO_POS] = config_timeout_flag_q;
        rd_d[IRQ_CPWR_POS] = cable_power_drop_flag_q;
        rd_d[IRQ_STATE_TO_POS] = state_timeout_flag_q;
        rd_d[IRQ_PORT_EV_POS] = port_event_flag_q;
      end
      OFS_MODE: begin
        rd_d[MODE_FAST_POS] = fast_arbitration_enable_q;
        rd_d[MODE_MIXED_POS] = mixed_speed_concat_enable_q;
        rd_d[MODE_LEGACY_POS +: 3] = legacy_path_top_speed_q;
        rd_d[MODE_BETA_POS] = beta_mode_strap;
        rd_d[MODE_BRIDGE_POS +: 2] = bridge_q;
      end
      OFS_SELECT: begin
        rd_d[SEL_PAGE_POS +: 3] = page_q;
        rd_d[SEL_PORT_POS +: 4] = port_q;
      end
      OFS_SELFID: begin
        rd_d[23:18] = {pwr_class_q, contender_q, bridge_q};
      end
      OFS_PORT_STAT: begin
        if (page_q == 3'h0 && port_q < NUM_PORTS) begin
          rd_d[0] = port_stat.connected[port_q[1:0]];
          rd_d[1] = port_stat.bias[port_q[1:0]];
          rd_d[2] = port_stat.disabled[port_q[1:0]];
          rd_d[3] = port_stat.fault[port_q[1:0]];
          rd_d[4] = port_event_enable[port_q[1:0]];
        end // else reads zero
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // apb answer registered; unmapped addresses give pslverr
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(hit(paddr, OFS_CONFIG) || hit(paddr, OFS_IRQ) ||
                 hit(paddr, OFS_MODE) || hit(paddr, OFS_SELECT) || hit(paddr, OFS_SELFID) ||
                 hit(paddr, OFS_PORT_STAT));
      if (psel && !penable && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // assertions
  a_selfid_contender: assert property (@(posedge core_clk) disable iff (sys_rst)
    selfid_bits[SID_CONTENDER_BIT] == $past(contender_q)) else $error("contender not in self-id");
  a_short_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    bus_reset_start && !(wr_en && hit(paddr, OFS_CONFIG)) |=> !short_reset_request_q)
    else $error("short request not cleared by bus reset");
  a_state_to_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    arb.state_timeout && rst_state_q == ST_IDLE |=> bus_reset_start && bus_reset_long)
    else $error("state timeout without bus reset");
  a_cps_fall_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(cable_power_sense) |=> cable_power_drop_flag_q) else $error("power drop not flagged");
  a_cfg_to_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    arb.cfg_timeout |=> config_timeout_flag_q) else $error("config timeout lost");
  a_flag_zero_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_en && hit(paddr, OFS_IRQ) && !pwdata[IRQ_STATE_TO_POS] && state_timeout_flag_q
    |=> state_timeout_flag_q) else $error("zero write cleared flag");
  a_link_on_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    link_on_output |-> $past(resume_watch_irq_enable_q) && !$past(link_active))
    else $error("link-on without cause");
  a_beta_masks: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(beta_mode_active) |-> !fast_arb_active && !mixed_concat_active)
    else $error("fast options active in beta mode");
  a_legacy_cap: assert property (@(posedge core_clk) disable iff (sys_rst)
    legacy_path_top_speed_q <= SPEED_S400) else $error("legacy speed above cap");
  a_short_len: assert property (@(posedge core_clk) disable iff (sys_rst)
    rst_state_q == ST_IDLE ##1 rst_state_q == ST_SHORT |-> rst_state_q == ST_SHORT [*8])
    else $error("short reset too brief");
endmodule

// *** pkg/sbp_pkg.sv ***
// package for the serial bus phy base configuration register bank
package sbp_pkg;
  // register byte offsets on the apb
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_IRQ = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_SELECT = 8'h0C;
  localparam logic [7:0] OFS_SELFID = 8'h10;
  localparam logic [7:0] OFS_PORT_STAT = 8'h14;
  // config register fields
  localparam int CFG_CONTENDER_POS = 0;
  localparam int CFG_SKEW_POS = 4;
  localparam int CFG_PWR_POS = 8;
  localparam int CFG_WATCH_POS = 12;
  localparam int CFG_SHORT_RST_POS = 13;
  // irq register fields
  localparam int IRQ_CFG_TO_POS = 0;
  localparam int IRQ_CPWR_POS = 1;
  localparam int IRQ_STATE_TO_POS = 2;
  localparam int IRQ_PORT_EV_POS = 3;
  // mode register fields
  localparam int MODE_FAST_POS = 0;
  localparam int MODE_MIXED_POS = 1;
  localparam int MODE_LEGACY_POS = 4;
  localparam int MODE_BETA_POS = 8;
  localparam int MODE_BRIDGE_POS = 12;
  // select register fields
  localparam int SEL_PAGE_POS = 0;
  localparam int SEL_PORT_POS = 4;
  // self-id packet bit positions
  localparam int SID_CONTENDER_BIT = 20;
  localparam int SID_PWR_POS = 21;
  localparam int SID_BRIDGE_POS = 18;
  // reset values, fixed skew, speed cap and port count
  localparam logic [2:0] SKEW_VALUE = 3'h0;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  localparam logic [3:0] PORT_RESET = 4'h0;
  localparam logic [1:0] BRIDGE_RESET = 2'h0;
  localparam logic [2:0] SPEED_S400 = 3'h2;
  localparam logic [3:0] NUM_PORTS = 4'h3;
  // timing of the short reset
  localparam real SHORT_RESET_NS = 1300.0;
  localparam real CLK_PERIOD_NS = 50.0;
  localparam int SHORT_RESET_CYC = int'($ceil(SHORT_RESET_NS / CLK_PERIOD_NS));
  localparam logic [7:0] SHORT_RESET_CNT = 8'(SHORT_RESET_CYC);

  // per-port status and events
  typedef struct packed {
    logic [2:0] connected;
    logic [2:0] bias;
    logic [2:0] disabled;
    logic [2:0] fault;
    logic [2:0] resume_start;
  } sbp_port_type;

  // bus state handed in by the arbitration core
  typedef struct packed {
    logic cfg_timeout;
    logic state_timeout;
    logic bus_reset_done;
    logic legacy_no_short;
    logic legacy_speed_valid;
    logic [2:0] legacy_speed;
  } sbp_arb_type;
endpackage

// *** testbench/sbp_arb_model.sv ***
// arbitration core stand-in: bus events and the end of long bus resets
`timescale 1ns/1ps
module sbp_arb_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic bus_reset_long,
  input wire logic cfg_to_req,
  input wire logic state_to_req,
  input wire logic no_short,
  input wire logic spd_valid,
  input wire logic [2:0] spd,
  input wire logic [7:0] done_delay,
  output sbp_pkg::sbp_arb_type arb
);
  import sbp_pkg::*;
  logic [7:0] cnt_q;
  // age of the long reset; saturates so completion is reported only once
  always_ff @(posedge core_clk) begin
    if (sys_rst || !bus_reset_long) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hFF) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // speed lines carry garbage outside the valid pulse, never the last value
  always_comb begin
    arb.cfg_timeout = cfg_to_req;
    arb.state_timeout = state_to_req;
    arb.bus_reset_done = bus_reset_long && cnt_q == done_delay;
    arb.legacy_no_short = no_short;
    arb.legacy_speed_valid = spd_valid;
    arb.legacy_speed = spd_valid ? spd : ~spd;
  end
endmodule

// *** testbench/serial_bus_phy_base_config_bits_tb.sv ***
// self-checking bench for the serial bus phy base configuration register bank
`timescale 1ns/1ps
module serial_bus_phy_base_config_bits_tb;
  import sbp_pkg::*;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic beta_mode_strap, beta_mode_active, cable_power_sense, link_active;
  logic cfg_to_req, state_to_req, no_short, spd_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, r;
  logic [2:0] power_class_straps, port_event_enable, spd;
  logic [23:18] selfid_bits;
  logic bus_reset_start, bus_reset_long, bus_reset_active, link_on_output, fast_arb_active, mixed_concat_active;
  logic rerr;
  sbp_port_type port_stat;
  sbp_arb_type arb;
  int err_count, comparisons, cycles, starts, act_cyc, long_cyc, p, idx;
  int m_con, m_pwr, m_watch, m_flags, m_fast, m_mixed, m_legacy, m_bridge, m_page, m_port;

  sbp_regs u_sbp_regs (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_class_straps(power_class_straps), .beta_mode_strap(beta_mode_strap),
    .beta_mode_active(beta_mode_active), .cable_power_sense(cable_power_sense), .link_active(link_active),
    .port_stat(port_stat), .port_event_enable(port_event_enable), .arb(arb), .selfid_bits(selfid_bits),
    .bus_reset_start(bus_reset_start), .bus_reset_long(bus_reset_long), .bus_reset_active(bus_reset_active),
    .link_on_output(link_on_output), .fast_arb_active(fast_arb_active), .mixed_concat_active(mixed_concat_active));
  sbp_arb_model u_sbp_arb_model (.core_clk(core_clk), .sys_rst(sys_rst), .bus_reset_long(bus_reset_long),
    .cfg_to_req(cfg_to_req), .state_to_req(state_to_req), .no_short(no_short), .spd_valid(spd_valid),
    .spd(spd), .done_delay(8'h28), .arb(arb));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // watches reset activity; the cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (bus_reset_start === 1'b1) starts++;
    if (bus_reset_active === 1'b1) act_cyc++;
    if (bus_reset_long === 1'b1) long_cyc++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one apb transfer; an idle edge follows so psel is never reassigned in one step
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, $urandom);
    chk(what, rdv, exp);
    chk("pslverr", {31'h0, rerr}, {31'h0, a > OFS_PORT_STAT});
  endtask
  task automatic pulse_to(input logic st);
    if (st) state_to_req <= 1'b1;
    else cfg_to_req <= 1'b1;
    tick(1);
    {cfg_to_req, state_to_req} <= 2'b00;
    tick(3);
  endtask
  // reads every register except port status back against the model, then the self-id bits and the fast and mixed outputs
  task automatic check_all();
    int cw, mw, sid;
    cw = m_con | m_pwr << CFG_PWR_POS | m_watch << CFG_WATCH_POS;
    mw = m_fast | m_mixed << MODE_MIXED_POS | m_legacy << MODE_LEGACY_POS | m_bridge << MODE_BRIDGE_POS;
    mw = mw | int'(beta_mode_strap) << MODE_BETA_POS;
    sid = m_pwr << SID_PWR_POS | m_con << SID_CONTENDER_BIT | m_bridge << SID_BRIDGE_POS;
    rdchk(OFS_CONFIG, 32'(cw), "config");
    rdchk(OFS_IRQ, 32'(m_flags), "irq");
    rdchk(OFS_MODE, 32'(mw), "mode");
    rdchk(OFS_SELECT, 32'(m_page | m_port << SEL_PORT_POS), "select");
    rdchk(OFS_SELFID, 32'(sid), "selfid reg");
    chk("selfid bits", 32'({selfid_bits, 18'h0}), 32'(sid));
    chk("fast", 32'(fast_arb_active), 32'(m_fast != 0 && beta_mode_active === 1'b0));
    chk("mixed", 32'(mixed_concat_active), 32'(m_mixed != 0 && beta_mode_active === 1'b0));
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    tick(10);
    sys_rst <= 1'b0;
    {m_con, m_watch, m_fast, m_mixed, m_legacy, m_bridge, m_page, m_port} = '0;
    m_pwr = power_class_straps;
    m_flags = 2;
    tick(1);
  endtask
  task automatic done_test(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, beta_mode_active} = '0;
    sys_rst = 1'b1; // keeps the checkers quiet until the first reset has run
    {cfg_to_req, state_to_req, no_short, spd_valid, spd, port_stat, port_event_enable} = '0;
    {cable_power_sense, link_active} = 2'b11;
    void'($urandom(32'h4C25));
    power_class_straps = 3'($urandom);
    beta_mode_strap = 1'($urandom);
    tick(1);
    do_reset();
    check_all();
    done_test("reset values");
    // random field writes, read-only bits included, beta mode toggled
    repeat (4) begin
      r = $urandom;
      wr(OFS_CONFIG, r & 32'hFFFF_CFFF);
      wr(OFS_MODE, r >> 1);
      wr(OFS_SELECT, r >> 16);
      beta_mode_active <= r[20];
      m_con = r[0];
      m_pwr = r[10:8];
      m_fast = r[1];
      m_mixed = r[2];
      m_bridge = r[14:13];
      m_page = r[18:16];
      m_port = r[23:20];
      check_all();
    end
    done_test("field writes");
    // short request, once plain and once against a legacy node
    for (int ns = 0; ns < 2; ns++) begin
      no_short <= ns[0];
      power_class_straps <= ~power_class_straps;
      {starts, act_cyc, long_cyc} = '0;
      wr(OFS_CONFIG, 32'(m_con | m_pwr << CFG_PWR_POS) | 32'h2000);
      do tick(1); while (act_cyc == 0 || bus_reset_active === 1'b1);
      chk("reset starts", 32'(starts), 32'h1);
      chk("long reset", 32'(long_cyc > 0), 32'(ns));
      r = ns ? 32'(act_cyc > 40) : 32'(act_cyc >= SHORT_RESET_CYC && act_cyc <= SHORT_RESET_CYC + 2);
      chk("reset length", r, 32'h1);
      spd_valid <= 1'b1;
      spd <= ns ? 3'h5 : 3'h1;
      tick(1);
      spd <= 3'h0;
      tick(1);
      spd_valid <= 1'b0;
      tick(2);
      m_legacy = ns ? 2 : 1;
      check_all();
    end
    done_test("bus resets");
    // write-one-to-clear flags and their setting events
    wr(OFS_IRQ, 32'h0);
    check_all();
    wr(OFS_IRQ, 32'h2);
    m_flags = 0;
    check_all();
    cable_power_sense <= 1'b0;
    tick(2);
    cable_power_sense <= 1'b1;
    tick(2);
    pulse_to(1'b0);
    {starts, act_cyc} = '0;
    pulse_to(1'b1);
    do tick(1); while (act_cyc == 0 || bus_reset_active === 1'b1);
    chk("timeout reset", 32'(starts), 32'h1);
    m_flags = 7;
    m_legacy = 0;
    check_all();
    wr(OFS_IRQ, 32'h8); // zero on the set state flag, one on the clear port flag
    wr(OFS_IRQ, 32'h5);
    m_flags = 2;
    check_all();
    p = $urandom_range(2, 0);
    port_event_enable <= 3'(1 << p);
    idx = 3 + 3 * $urandom_range(3, 0) + (p + 1) % 3;
    port_stat[idx] <= ~port_stat[idx];
    tick(3);
    check_all();
    idx = 3 + 3 * $urandom_range(3, 0) + p;
    port_stat[idx] <= ~port_stat[idx];
    tick(3);
    m_flags = 10;
    check_all();
    done_test("flags");
    // link-on notification and resume watch
    wr(OFS_IRQ, 32'hF);
    m_flags = 0;
    link_active <= 1'b0;
    port_stat.resume_start <= 3'(1 << p);
    tick(1);
    port_stat.resume_start <= 3'h0;
    tick(2);
    check_all();
    m_watch = 1;
    wr(OFS_CONFIG, 32'(m_con | m_pwr << CFG_PWR_POS) | 32'h1000);
    tick(2);
    chk("link on idle", 32'(link_on_output), 32'h0);
    pulse_to(1'b0);
    m_flags = 1;
    chk("link on", 32'(link_on_output), 32'h1);
    link_active <= 1'b1;
    tick(2);
    chk("link on active", 32'(link_on_output), 32'h0);
    link_active <= 1'b0;
    tick(2);
    chk("link on again", 32'(link_on_output), 32'h1);
    wr(OFS_IRQ, 32'h1);
    port_stat.resume_start <= 3'(1 << p);
    tick(1);
    port_stat.resume_start <= 3'h0;
    tick(2);
    m_flags = 8;
    chk("link on port", 32'(link_on_output), 32'h0);
    check_all();
    done_test("link on");
    // port status page for port choices 0 to 3, then another page
    port_stat[14:3] <= 12'($urandom);
    port_event_enable <= 3'($urandom);
    tick(3);
    for (int q = 0; q < 4; q++) begin
      wr(OFS_SELECT, 32'(q << SEL_PORT_POS));
      r = q < 3 ? 32'({port_event_enable[q], port_stat.fault[q], port_stat.disabled[q],
        port_stat.bias[q], port_stat.connected[q]}) : 32'h0;
      rdchk(OFS_PORT_STAT, r, "port status");
    end
    wr(OFS_SELECT, 32'h1);
    rdchk(OFS_PORT_STAT, 32'h0, "other page");
    wr(8'h18, $urandom);
    chk("unmapped write", {31'h0, rerr}, 32'h1);
    rdchk(8'h18, 32'h0, "unmapped read");
    rdchk(OFS_SELECT, 32'h1, "select kept");
    done_test("port page");
    // second reset in mid-run
    port_stat[14:3] <= 12'h000;
    tick(3);
    do_reset();
    check_all();
    done_test("second reset");
    end_of_test();
  end
endmodule
